/* File: pkg/irq_prio_pkg.sv */
// constants for the vectored interrupt priority unit
package irq_prio_pkg;
  localparam int unsigned NUM_MASKABLE = 19;
  localparam int unsigned NUM_EDGE_PINS = 6;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned VEC_W = 16;

  // register offsets
  localparam logic [3:0] OFS_REQ_A = 4'h0;
  localparam logic [3:0] OFS_REQ_B = 4'h1;
  localparam logic [3:0] OFS_REQ_C = 4'h2;
  localparam logic [3:0] OFS_MASK_A = 4'h3;
  localparam logic [3:0] OFS_MASK_B = 4'h4;
  localparam logic [3:0] OFS_MASK_C = 4'h5;
  localparam logic [3:0] OFS_PRIO_LOW_A = 4'h6;
  localparam logic [3:0] OFS_PRIO_HIGH_A = 4'h7;
  localparam logic [3:0] OFS_PRIO_LOW_B = 4'h8;
  localparam logic [3:0] OFS_RISE_EN = 4'h9;
  localparam logic [3:0] OFS_FALL_EN = 4'ha;
  localparam logic [3:0] OFS_CONTROL = 4'hb;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // reset values
  localparam logic [18:0] RST_REQ = 19'h00000;
  localparam logic [18:0] RST_MASK = 19'h7ffff;
  localparam logic [18:0] RST_PRIO = 19'h7ffff;
  localparam logic [5:0] RST_EDGE_EN = 6'h00;
  localparam logic RST_WDT_NMI_MODE = 1'b1;

  // field positions
  localparam int unsigned CTL_WDT_NMI_BIT = 0;
  localparam int unsigned SRC_WATCHDOG = 0;
  localparam int unsigned SRC_CAPTURE_0 = 3;
  localparam int unsigned SRC_PIN_0 = 6;

  // vector table
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_MASKABLE_BASE = 16'h0004;
  localparam logic [15:0] VEC_BREAK = 16'h003e;

  // service levels held on the nesting stack
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_NMI = 2'h3;

  // kind of the offered request
  localparam logic [1:0] KIND_MASKABLE = 2'h0;
  localparam logic [1:0] KIND_NMI = 2'h1;
  localparam logic [1:0] KIND_BREAK = 2'h2;

  typedef enum logic [2:0] {
    ARB_IDLE = 3'b001,
    ARB_OFFER = 3'b010,
    ARB_SETTLE = 3'b100
  } arb_state_t;
endpackage

/* File: design/vectored_interrupt_priority_unit.sv */
// vectored interrupt priority unit: masking, two-group priority, nesting, vector hand-off
//
// Functional notes
// - non-maskable request ignores processor enable
// - non-maskable request wins arbitration unless an nmi is already in service or the stack is full
// - pending unmasked and non-maskable requests raise standby release
// - watchdog in non-maskable mode vectors 0004H
// - watchdog in interval mode is maskable priority 0
// - set mask flag blocks its request
// - priority flags split sources high/low groups
// - high group nests over low service
// - equal group ties use default ranking
// - six pin-edge (capture 3-5, pin 6-8) and thirteen internal maskables
// - break request ignores enable and priority
// - twenty-one sources handled in total
// - converter 1/0006H, wide timer 2/0008H
// - capture edges 3-5 at 000AH-000EH
// - pin edges 6-8 at 0010H-0014H
// - clocked serial done 9 at 0016H
// - async receive error 10 at 0018H
// - async rx/tx done 11,12 at 001AH/001CH
// - compare matches 13-15 at 001EH-0022H
// - nv write, watch 16-18 at 0024H-0028H
// - lowest default priority value wins
`timescale 1ns/10ps
`default_nettype none
module vectored_interrupt_priority_unit (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [irq_prio_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [irq_prio_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [irq_prio_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic watchdog_overflow_request_in,
  input wire logic converter_done_request_in,
  input wire logic wide_timer_overflow_request_in,
  input wire logic capture_input_0_in,
  input wire logic capture_input_1_in,
  input wire logic capture_input_2_in,
  input wire logic pin_edge_request_0_in,
  input wire logic pin_edge_request_1_in,
  input wire logic pin_edge_request_2_in,
  input wire logic clocked_serial_done_request_in,
  input wire logic async_rx_error_request_in,
  input wire logic async_rx_done_request_in,
  input wire logic async_tx_done_request_in,
  input wire logic compare_match_request_1_in,
  input wire logic compare_match_request_2_in,
  input wire logic compare_match_request_3_in,
  input wire logic nv_write_done_request_in,
  input wire logic watch_overflow_request_in,
  input wire logic watch_interval_request_in,
  input wire logic break_instruction_in,
  input wire logic core_int_enable_in,
  input wire logic core_ack_in,
  input wire logic core_return_in,
  output logic core_request_out,
  output logic [irq_prio_pkg::VEC_W-1:0] core_vector_out,
  output logic standby_release_out
);
  import irq_prio_pkg::*;

  // lowest set index of a request vector, default ranking
  function automatic logic [4:0] first_set(input logic [18:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] maskable_vector(input logic [4:0] idx);
    return VEC_MASKABLE_BASE + {10'h000, idx, 1'b0};
  endfunction

  logic [18:0] req_flags_r;
  logic [18:0] mask_flags_r;
  logic [18:0] prio_flags_r;
  logic [5:0] rise_en_r;
  logic [5:0] fall_en_r;
  logic wdt_nmi_mode_r;
  logic nmi_pending_r;
  logic break_pending_r;
  logic [5:0] edge_meta_r;
  logic [5:0] edge_sync_r;
  logic [5:0] edge_prev_r;
  logic [1:0] stack_r [STACK_DEPTH];
  logic [3:0] depth_r;
  arb_state_t state_r;
  arb_state_t state_nxt;
  logic [1:0] sel_kind_r;
  logic [4:0] sel_index_r;
  logic [1:0] sel_level_r;

  logic [5:0] edge_raw;
  logic [5:0] edge_hit;
  logic [18:0] hw_set;
  logic [18:0] ack_clear;
  logic [18:0] sw_value;
  logic [18:0] sw_strobe;
  logic [18:0] enabled_req;
  logic [18:0] high_req;
  logic [18:0] low_req;
  logic [1:0] top_level;
  logic stack_full;
  logic win_valid;
  logic [1:0] win_kind;
  logic [4:0] win_index;
  logic [1:0] win_level;
  logic [15:0] win_vector;
  logic ack_take;

  assign edge_raw = {pin_edge_request_2_in, pin_edge_request_1_in, pin_edge_request_0_in,
                     capture_input_2_in, capture_input_1_in, capture_input_0_in};

  // pins come from outside the clock domain
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      edge_meta_r <= 6'h00;
      edge_sync_r <= 6'h00;
      edge_prev_r <= 6'h00;
    end else begin
      edge_meta_r <= edge_raw;
      edge_sync_r <= edge_meta_r;
      edge_prev_r <= edge_sync_r;
    end
  end

  assign edge_hit = (edge_sync_r & ~edge_prev_r & rise_en_r) | (~edge_sync_r & edge_prev_r & fall_en_r);

  always_comb begin
    hw_set = 19'h00000;
    hw_set[SRC_WATCHDOG] = watchdog_overflow_request_in & ~wdt_nmi_mode_r;
    hw_set[1] = converter_done_request_in;
    hw_set[2] = wide_timer_overflow_request_in;
    hw_set[SRC_CAPTURE_0 +: 3] = edge_hit[2:0];
    hw_set[SRC_PIN_0 +: 3] = edge_hit[5:3];
    hw_set[9] = clocked_serial_done_request_in;
    hw_set[10] = async_rx_error_request_in;
    hw_set[11] = async_rx_done_request_in;
    hw_set[12] = async_tx_done_request_in;
    hw_set[13] = compare_match_request_1_in;
    hw_set[14] = compare_match_request_2_in;
    hw_set[15] = compare_match_request_3_in;
    hw_set[16] = nv_write_done_request_in;
    hw_set[17] = watch_overflow_request_in;
    hw_set[18] = watch_interval_request_in;
  end

  // software access to a flag group of three bytes
  always_comb begin
    sw_value = 19'h00000;
    sw_strobe = 19'h00000;
    if (reg_write_in) begin
      case (reg_addr_in)
        OFS_REQ_A: begin
          sw_value[7:0] = reg_wdata_in;
          sw_strobe[7:0] = 8'hff;
        end
        OFS_REQ_B: begin
          sw_value[15:8] = reg_wdata_in;
          sw_strobe[15:8] = 8'hff;
        end
        OFS_REQ_C: begin
          sw_value[18:16] = reg_wdata_in[2:0];
          sw_strobe[18:16] = 3'h7;
        end
        default: begin
          sw_strobe = 19'h00000;
        end
      endcase
    end
  end

  assign ack_take = (state_r == ARB_OFFER) && core_ack_in;

  always_comb begin
    ack_clear = 19'h00000;
    if (ack_take && sel_kind_r == KIND_MASKABLE) begin
      ack_clear[sel_index_r] = 1'b1;
    end
  end

  // a hardware set in the same cycle as a clear is kept
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      req_flags_r <= RST_REQ;
    end else begin
      req_flags_r <= (((req_flags_r & ~sw_strobe) | (sw_value & sw_strobe)) & ~ack_clear) | hw_set;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mask_flags_r <= RST_MASK;
      prio_flags_r <= RST_PRIO;
      rise_en_r <= RST_EDGE_EN;
      fall_en_r <= RST_EDGE_EN;
      wdt_nmi_mode_r <= RST_WDT_NMI_MODE;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        OFS_MASK_A: mask_flags_r[7:0] <= reg_wdata_in;
        OFS_MASK_B: mask_flags_r[15:8] <= reg_wdata_in;
        OFS_MASK_C: mask_flags_r[18:16] <= reg_wdata_in[2:0];
        OFS_PRIO_LOW_A: prio_flags_r[7:0] <= reg_wdata_in;
        OFS_PRIO_HIGH_A: prio_flags_r[15:8] <= reg_wdata_in;
        OFS_PRIO_LOW_B: prio_flags_r[18:16] <= reg_wdata_in[2:0];
        OFS_RISE_EN: rise_en_r <= reg_wdata_in[5:0];
        OFS_FALL_EN: fall_en_r <= reg_wdata_in[5:0];
        OFS_CONTROL: wdt_nmi_mode_r <= reg_wdata_in[CTL_WDT_NMI_BIT];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      nmi_pending_r <= 1'b0;
    end else if (watchdog_overflow_request_in && wdt_nmi_mode_r) begin
      nmi_pending_r <= 1'b1;
    end else if (ack_take && sel_kind_r == KIND_NMI) begin
      nmi_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      break_pending_r <= 1'b0;
    end else if (break_instruction_in) begin
      break_pending_r <= 1'b1;
    end else if (ack_take && sel_kind_r == KIND_BREAK) begin
      break_pending_r <= 1'b0;
    end
  end

  assign top_level = (depth_r == 4'h0) ? LVL_NONE : stack_r[3'(depth_r - 4'h1)];
  assign stack_full = (depth_r == 4'(STACK_DEPTH));
  assign enabled_req = req_flags_r & ~mask_flags_r;
  assign high_req = enabled_req & ~prio_flags_r;
  assign low_req = enabled_req & prio_flags_r;

  // nmi, then break, then high group, then low group
  always_comb begin
    win_valid = 1'b0;
    win_kind = KIND_MASKABLE;
    win_index = 5'h00;
    win_level = LVL_NONE;
    win_vector = VEC_NMI;
    if (stack_full) begin
      win_valid = 1'b0;
    end else if (nmi_pending_r && top_level != LVL_NMI) begin
      win_valid = 1'b1;
      win_kind = KIND_NMI;
      win_level = LVL_NMI;
      win_vector = VEC_NMI;
    end else if (break_pending_r) begin
      win_valid = 1'b1;
      win_kind = KIND_BREAK;
      win_level = top_level;
      win_vector = VEC_BREAK;
    end else if (core_int_enable_in && (|high_req) && top_level < LVL_HIGH) begin
      win_valid = 1'b1;
      win_index = first_set(high_req);
      win_level = LVL_HIGH;
      win_vector = maskable_vector(first_set(high_req));
    end else if (core_int_enable_in && (|low_req) && top_level < LVL_LOW) begin
      win_valid = 1'b1;
      win_index = first_set(low_req);
      win_level = LVL_LOW;
      win_vector = maskable_vector(first_set(low_req));
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ARB_IDLE: begin
        if (win_valid) begin
          state_nxt = ARB_OFFER;
        end
      end
      ARB_OFFER: begin
        if (core_ack_in) begin
          state_nxt = ARB_SETTLE;
        end else if (!win_valid) begin
          state_nxt = ARB_IDLE;
        end
      end
      ARB_SETTLE: state_nxt = ARB_IDLE;
      default: state_nxt = ARB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= ARB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the offer follows the winner each cycle until taken, so a late nmi still overtakes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sel_kind_r <= KIND_MASKABLE;
      sel_index_r <= 5'h00;
      sel_level_r <= LVL_NONE;
      core_vector_out <= VEC_NMI;
      core_request_out <= 1'b0;
    end else begin
      core_request_out <= (state_nxt == ARB_OFFER);
      if ((state_r == ARB_IDLE || (state_r == ARB_OFFER && !core_ack_in)) && win_valid) begin
        sel_kind_r <= win_kind;
        sel_index_r <= win_index;
        sel_level_r <= win_level;
        core_vector_out <= win_vector;
      end
    end
  end

  // nesting stack: acknowledge pushes the entered level, return pops it
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      depth_r <= 4'h0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= LVL_NONE;
      end
    end else if (ack_take && core_return_in && depth_r != 4'h0) begin
      stack_r[3'(depth_r - 4'h1)] <= sel_level_r;
    end else if (ack_take) begin
      stack_r[3'(depth_r)] <= sel_level_r;
      depth_r <= depth_r + 4'h1;
    end else if (core_return_in && depth_r != 4'h0) begin
      depth_r <= depth_r - 4'h1;
    end
  end

  // wakes the core even while the core has interrupts disabled
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      standby_release_out <= 1'b0;
    end else begin
      standby_release_out <= nmi_pending_r | (|enabled_req);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        OFS_REQ_A: reg_rdata_out <= req_flags_r[7:0];
        OFS_REQ_B: reg_rdata_out <= req_flags_r[15:8];
        OFS_REQ_C: reg_rdata_out <= {5'h00, req_flags_r[18:16]};
        OFS_MASK_A: reg_rdata_out <= mask_flags_r[7:0];
        OFS_MASK_B: reg_rdata_out <= mask_flags_r[15:8];
        OFS_MASK_C: reg_rdata_out <= {5'h00, mask_flags_r[18:16]};
        OFS_PRIO_LOW_A: reg_rdata_out <= prio_flags_r[7:0];
        OFS_PRIO_HIGH_A: reg_rdata_out <= prio_flags_r[15:8];
        OFS_PRIO_LOW_B: reg_rdata_out <= {5'h00, prio_flags_r[18:16]};
        OFS_RISE_EN: reg_rdata_out <= {2'h0, rise_en_r};
        OFS_FALL_EN: reg_rdata_out <= {2'h0, fall_en_r};
        OFS_CONTROL: reg_rdata_out <= {7'h00, wdt_nmi_mode_r};
        OFS_STATUS: reg_rdata_out <= {depth_r, top_level, break_pending_r, nmi_pending_r};
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end
endmodule // vectored_interrupt_priority_unit
`default_nettype wire

/* File: tb/vipu_asserts.sv */
// port-level assertions for the vectored interrupt priority unit
`timescale 1ns/10ps
`default_nettype none
module vipu_asserts (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [irq_prio_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_read_in,
  input wire logic [irq_prio_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic break_instruction_in,
  input wire logic core_int_enable_in,
  input wire logic core_ack_in,
  input wire logic core_request_out,
  input wire logic [irq_prio_pkg::VEC_W-1:0] core_vector_out,
  input wire logic standby_release_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  a_vec_in_table: assert property (core_request_out |-> !core_vector_out[0] &&
    core_vector_out inside {[16'h0004:16'h0028], 16'h003e})
    else $error("offered vector outside the table");
  a_ack_gap: assert property (core_request_out && core_ack_in |=> !core_request_out [*2])
    else $error("offer not withdrawn after acknowledge");
  a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (reg_read_in && reg_addr_in > 4'hc |=> reg_rdata_out == 8'h00)
    else $error("unmapped offset read not zero");
  a_flag_count: assert property (reg_read_in && reg_addr_in == 4'h2 |=> reg_rdata_out[7:3] == 5'h00)
    else $error("flag bits beyond source count");
  a_break_offer: assert property (break_instruction_in |-> ##[1:4] core_request_out)
    else $error("break request not offered");
  a_standby_up: assert property ($rose(core_request_out) && core_vector_out != 16'h003e |->
    standby_release_out)
    else $error("standby release missing with offer");
  a_ie_gates: assert property (core_request_out && !$past(core_int_enable_in) |->
    core_vector_out inside {16'h0004, 16'h003e})
    else $error("maskable offered while disabled");
endmodule // vipu_asserts
`default_nettype wire

/* File: tb/vipu_core_model.sv */
// core stand-in: acknowledges offered vectors and returns from handlers
`timescale 1ns/10ps
`default_nettype none
module vipu_core_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic core_request_in,
  input wire logic [3:0] ack_delay_in,
  input wire logic [7:0] return_delay_in,
  output logic ack_out,
  output logic return_out
);
  logic [3:0] wait_r;
  logic [7:0] timer_r;
  logic [3:0] depth_r;
  // a slow acknowledge lets a stronger late request take over the offer
  always_ff @(posedge clk_in) begin
    if (reset_in || ack_out || !core_request_in) begin
      ack_out <= 1'b0;
      wait_r <= 4'h0;
    end else if (wait_r == ack_delay_in) begin
      ack_out <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
  // one return per acknowledged handler, spaced by the handler run time
  always_ff @(posedge clk_in) begin
    return_out <= 1'b0;
    if (reset_in) begin
      depth_r <= 4'h0;
      timer_r <= 8'h00;
    end else if (ack_out) begin
      depth_r <= depth_r + 4'h1;
      timer_r <= return_delay_in;
    end else if (depth_r != 4'h0) begin
      if (timer_r == 8'h00) begin
        return_out <= 1'b1;
        depth_r <= depth_r - 4'h1;
        timer_r <= return_delay_in;
      end else begin
        timer_r <= timer_r - 8'h01;
      end
    end
  end
endmodule // vipu_core_model
`default_nettype wire

/* File: tb/vectored_interrupt_priority_unit_tb_top.sv */
// self-checking bench for the vectored interrupt priority unit
`timescale 1ns/10ps
`default_nettype none
module vectored_interrupt_priority_unit_tb_top;
  import irq_prio_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic [18:0] src_r = 19'h00000;
  logic break_instruction_in = 1'b0;
  logic core_int_enable_in = 1'b0;
  logic [3:0] ack_dly_r = 4'h0;
  logic [7:0] ret_dly_r = 8'h02;
  logic [7:0] reg_rdata_out;
  logic [15:0] core_vector_out;
  logic core_request_out, standby_release_out, core_ack_in, core_return_in;
  logic [15:0] exp_q[$];
  logic [18:0] pick_r;
  logic [7:0] wr_r;
  logic rd_seen = 1'b0;
  int bad_count = 0;
  int checks = 0;
  int seed = 69;
  int cyc = 0;
  always #2 clk_in = ~clk_in;
  vectored_interrupt_priority_unit vectored_interrupt_priority_unit_inst (.clk_in, .reset_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .watchdog_overflow_request_in(src_r[0]),
    .converter_done_request_in(src_r[1]), .wide_timer_overflow_request_in(src_r[2]),
    .capture_input_0_in(src_r[3]), .capture_input_1_in(src_r[4]), .capture_input_2_in(src_r[5]),
    .pin_edge_request_0_in(src_r[6]), .pin_edge_request_1_in(src_r[7]), .pin_edge_request_2_in(src_r[8]),
    .clocked_serial_done_request_in(src_r[9]), .async_rx_error_request_in(src_r[10]),
    .async_rx_done_request_in(src_r[11]), .async_tx_done_request_in(src_r[12]),
    .compare_match_request_1_in(src_r[13]), .compare_match_request_2_in(src_r[14]),
    .compare_match_request_3_in(src_r[15]), .nv_write_done_request_in(src_r[16]),
    .watch_overflow_request_in(src_r[17]), .watch_interval_request_in(src_r[18]), .break_instruction_in,
    .core_int_enable_in, .core_ack_in, .core_return_in, .core_request_out, .core_vector_out, .standby_release_out);
  vipu_core_model vipu_core_model_inst (.clk_in, .reset_in, .core_request_in(core_request_out),
    .ack_delay_in(ack_dly_r), .return_delay_in(ret_dly_r), .ack_out(core_ack_in), .return_out(core_return_in));
  task automatic cmp(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    bad_count += exp_q.size();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic rd);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= !rd;
    reg_read_in <= rd;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
    reg_read_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] d);
    exp_q.push_back({8'h00, d});
    bus(a, 8'h00, 1'b1);
  endtask
  task automatic pulse(input logic [18:0] s, input logic b);
    @(posedge clk_in);
    src_r <= s;
    break_instruction_in <= b;
    @(posedge clk_in);
    src_r <= 19'h00000;
    break_instruction_in <= 1'b0;
  endtask
  // the extra cycles let the core model finish its returns
  task automatic drain(input int n);
    for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk_in);
    repeat (n) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    if (rd_seen) cmp({8'h00, reg_rdata_out}, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    if (core_request_out && core_ack_in) cmp(core_vector_out, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    rd_seen = reg_read_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(4'h3, 8'hff);
    rd(4'h8, 8'h07);
    rd(4'hb, 8'h01);
    rd(4'hd, 8'h00);
    drain(4);
    $display("test reset values done");
    bus(4'hb, 8'h00, 1'b0);
    for (int i = 3; i < 6; i++) bus(4'(i), 8'h00, 1'b0);
    bus(4'h9, 8'h3f, 1'b0);
    core_int_enable_in <= 1'b1;
    for (int i = 0; i < 19; i++) begin
      exp_q.push_back(16'h0004 + 16'(2 * i));
      ack_dly_r <= 4'($random(seed) & 3);
      ret_dly_r <= 8'($random(seed) & 3);
      pulse(19'h00001 << i, 1'b0);
      drain(8);
    end
    $display("test vector table done");
    repeat (6) begin
      core_int_enable_in <= 1'b0;
      pick_r = 19'($random(seed));
      for (int i = 0; i < 19; i++) if (pick_r[i]) exp_q.push_back(16'h0004 + 16'(2 * i));
      pulse(pick_r, 1'b0);
      repeat (6) @(posedge clk_in);
      core_int_enable_in <= 1'b1;
      drain(12);
    end
    $display("test default ranking done");
    bus(4'h6, 8'hfd, 1'b0);
    ret_dly_r <= 8'h1e;
    exp_q.push_back(16'h0008);
    pulse(19'h00004, 1'b0);
    drain(2);
    exp_q.push_back(16'h0006);
    pulse(19'h00002, 1'b0);
    drain(2);
    // both handlers still running: depth two, high level on top
    rd(4'hc, 8'h28);
    exp_q.push_back(16'h000e);
    pulse(19'h00020, 1'b0);
    drain(70);
    bus(4'h6, 8'hff, 1'b0);
    ret_dly_r <= 8'h02;
    $display("test nesting done");
    wr_r = 8'($random(seed));
    bus(4'h5, wr_r, 1'b0);
    rd(4'h5, {5'h00, wr_r[2:0]});
    bus(4'h5, 8'h00, 1'b0);
    bus(4'h3, 8'h10, 1'b0);
    // pin 1 now fires on its falling edge only
    bus(4'h9, 8'h2f, 1'b0);
    bus(4'ha, 8'h10, 1'b0);
    exp_q.push_back(16'h0012);
    pulse(19'h00090, 1'b0);
    drain(8);
    rd(4'h0, 8'h10);
    bus(4'h0, 8'h00, 1'b0);
    bus(4'h3, 8'h00, 1'b0);
    bus(4'h9, 8'h3f, 1'b0);
    bus(4'ha, 8'h00, 1'b0);
    $display("test masking done");
    bus(4'hb, 8'h01, 1'b0);
    core_int_enable_in <= 1'b0;
    exp_q.push_back(16'h0004);
    exp_q.push_back(16'h003e);
    exp_q.push_back(16'h0006);
    pulse(19'h00003, 1'b1);
    repeat (20) @(posedge clk_in);
    core_int_enable_in <= 1'b1;
    drain(8);
    rd(4'h0, 8'h00);
    drain(2);
    $display("test non-maskable and break done");
    end_of_test();
  end
endmodule // vectored_interrupt_priority_unit_tb_top
bind vectored_interrupt_priority_unit vipu_asserts vipu_asserts_inst (.clk_in, .reset_in, .reg_addr_in,
  .reg_read_in, .reg_rdata_out, .break_instruction_in, .core_int_enable_in, .core_ack_in, .core_request_out,
  .core_vector_out, .standby_release_out);
`default_nettype wire
